// ---- src/flagword_cfg.svh ----
// Addresses, bit positions and reset values of the flag word block
`ifndef FLAGWORD_CFG_SVH
`define FLAGWORD_CFG_SVH

`define WORK_REG_ADDR   8'hE0
`define FLAGS_REG_ADDR  8'hD0

`define CARRY_POS       7
`define HALF_POS        6
`define USER0_POS       5
`define BANKH_POS       4
`define BANKL_POS       3
`define SIGNED_POS      2
`define USER1_POS       1
`define PARITY_POS      0

`define WORK_RST        8'h00
`define FLAGS_RST       8'h00
`define BANK_BASE_RST   8'h00
`define RDATA_IDLE      8'h00

`endif

// ---- src/flagword_pkg.sv ----
// Types shared by the flag word block and its users
package flagword_pkg;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADD,
        OP_ADDC,
        OP_SUBB,
        OP_CLR_C,
        OP_SET_C,
        OP_CPL_C,
        OP_AND_C,
        OP_ANDN_C,
        OP_OR_C,
        OP_ORN_C,
        OP_MOV_C
    } alu_op_t;

endpackage

// ---- src/nibble_carry_adder.sv ----
// Eight-bit adder exposing the carries out of bits 3, 6 and 7
`timescale 1ns/1ps

module nibble_carry_adder (
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       cin,
    output logic      [7:0] sum,
    output logic            c3,
    output logic            c6,
    output logic            c7
);
    logic [4:0] lo;
    logic [3:0] mid;
    logic [1:0] hi;

    // Split so the nibble and bit-six carries come out directly
    always_comb begin
        lo  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        mid = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, lo[4]};
        hi  = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid[3]};
        sum = {hi[0], mid[2:0], lo[3:0]};
        c3  = lo[4];
        c6  = mid[3];
        c7  = hi[1];
    end

endmodule

// ---- src/program_status_flags.sv ----
// Work register and status flag word with their arithmetic datapath
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "flagword_cfg.svh"

module program_status_flags (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    input  wire logic                    alu_valid,
    input  wire flagword_pkg::alu_op_t   alu_op,
    input  wire logic [7:0]              alu_operand,
    input  wire logic                    bit_in,
    output logic      [7:0]              work_value,
    output logic      [7:0]              flags_value,
    output logic      [7:0]              bank_base
);
    import flagword_pkg::*;

    logic [7:0] work_r;
    logic [7:0] work_nxt;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] bank_base_r;
    logic [7:0] bank_base_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    logic [7:0] add_b;
    logic       add_cin;
    logic       is_sub;
    logic [7:0] add_sum;
    logic       add_c3;
    logic       add_c6;
    logic       add_c7;
    logic       res_carry;
    logic       res_half;
    logic       res_signed;

    function automatic logic parity_of(input logic [7:0] v);
        return ^v;
    endfunction

    // Each bank is eight bytes, so the base is the select times eight
    function automatic logic [7:0] bank_base_of(input logic [1:0] sel);
        return {3'b000, sel, 3'b000};
    endfunction

    function automatic logic is_arith(input alu_op_t op);
        return (op == OP_ADD) || (op == OP_ADDC) || (op == OP_SUBB);
    endfunction

    // Subtract runs as add of the inverted operand; carries become borrows
    always_comb begin
        is_sub  = alu_op == OP_SUBB;
        add_b   = is_sub ? ~alu_operand : alu_operand;
        add_cin = 1'b0;
        case (alu_op)
            OP_ADDC: add_cin = flags_r[`CARRY_POS];
            OP_SUBB: add_cin = ~flags_r[`CARRY_POS];
            default: add_cin = 1'b0;
        endcase
    end

    nibble_carry_adder u_adder (
        .a   (work_r),
        .b   (add_b),
        .cin (add_cin),
        .sum (add_sum),
        .c3  (add_c3),
        .c6  (add_c6),
        .c7  (add_c7)
    );

    always_comb begin
        res_carry  = is_sub ? ~add_c7 : add_c7;
        res_half   = is_sub ? ~add_c3 : add_c3;
        res_signed = add_c6 ^ add_c7;
    end

    // Datapath results override a bus write to the same bits in one cycle
    always_comb begin
        work_nxt  = work_r;
        flags_nxt = flags_r;
        if (reg_wr) begin
            case (reg_addr)
                `WORK_REG_ADDR: work_nxt = reg_wdata;
                `FLAGS_REG_ADDR: flags_nxt = reg_wdata;
                default: ;
            endcase
        end
        if (alu_valid) begin
            case (alu_op)
                OP_ADD, OP_ADDC, OP_SUBB: begin
                    work_nxt                = add_sum;
                    flags_nxt[`CARRY_POS]   = res_carry;
                    flags_nxt[`HALF_POS]    = res_half;
                    flags_nxt[`SIGNED_POS]  = res_signed;
                end
                OP_CLR_C: flags_nxt[`CARRY_POS] = 1'b0;
                OP_SET_C: flags_nxt[`CARRY_POS] = 1'b1;
                OP_CPL_C: flags_nxt[`CARRY_POS] = ~flags_r[`CARRY_POS];
                OP_AND_C: flags_nxt[`CARRY_POS] = flags_r[`CARRY_POS] & bit_in;
                OP_ANDN_C: flags_nxt[`CARRY_POS] = flags_r[`CARRY_POS] & ~bit_in;
                OP_OR_C: flags_nxt[`CARRY_POS] = flags_r[`CARRY_POS] | bit_in;
                OP_ORN_C: flags_nxt[`CARRY_POS] = flags_r[`CARRY_POS] | ~bit_in;
                OP_MOV_C: flags_nxt[`CARRY_POS] = bit_in;
                default: ;
            endcase
        end
        // Taken from the next work value so the bit never lags a cycle
        flags_nxt[`PARITY_POS] = parity_of(work_nxt);
        bank_base_nxt = bank_base_of(flags_nxt[`BANKH_POS:`BANKL_POS]);
    end

    // Read data stand only in the cycle after the strobe, zero otherwise
    always_comb begin
        rdata_nxt = `RDATA_IDLE;
        if (reg_rd) begin
            case (reg_addr)
                `WORK_REG_ADDR: rdata_nxt = work_r;
                `FLAGS_REG_ADDR: rdata_nxt = flags_r;
                default: rdata_nxt = `RDATA_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            work_r      <= `WORK_RST;
            flags_r     <= `FLAGS_RST;
            bank_base_r <= `BANK_BASE_RST;
            rdata_r     <= `RDATA_IDLE;
        end else if (ce) begin
            work_r      <= work_nxt;
            flags_r     <= flags_nxt;
            bank_base_r <= bank_base_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    assign reg_rdata   = rdata_r;
    assign work_value  = work_r;
    assign flags_value = flags_r;
    assign bank_base   = bank_base_r;

    // Reference arithmetic kept apart from the adder instance
    logic [8:0] ref_add;
    logic [4:0] ref_nib;
    logic       ref_ovf;
    logic       wr_flags;
    logic [8:0] ref_addc;
    logic [8:0] ref_sub;
    logic [4:0] ref_nib_sub;
    logic       wr_other;
    logic       rd_other;

    always_comb begin
        ref_add  = {1'b0, work_r} + {1'b0, alu_operand};
        ref_nib  = {1'b0, work_r[3:0]} + {1'b0, alu_operand[3:0]};
        ref_ovf  = (work_r[7] == alu_operand[7]) && (ref_add[7] != work_r[7]);
        wr_flags = reg_wr && (reg_addr == `FLAGS_REG_ADDR);
        // Borrow shows as bit 8 of the nine-bit difference
        ref_addc    = {1'b0, work_r} + {1'b0, alu_operand} + {8'h00, flags_r[`CARRY_POS]};
        ref_sub     = {1'b0, work_r} - {1'b0, alu_operand} - {8'h00, flags_r[`CARRY_POS]};
        ref_nib_sub = {1'b0, work_r[3:0]} - {1'b0, alu_operand[3:0]} - {4'h0, flags_r[`CARRY_POS]};
        wr_other    = reg_wr && (reg_addr != `WORK_REG_ADDR) && (reg_addr != `FLAGS_REG_ADDR);
        rd_other    = reg_rd && (reg_addr != `WORK_REG_ADDR) && (reg_addr != `FLAGS_REG_ADDR);
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    carry_on_add_a: assert property (
        ce && alu_valid && alu_op == OP_ADD |=> flags_r[`CARRY_POS] == $past(ref_add[8]))
        else $error("carry flag does not match add carry out");

    bit_and_a: assert property (
        ce && alu_valid && alu_op == OP_AND_C
        |=> flags_r[`CARRY_POS] == ($past(flags_r[`CARRY_POS]) & $past(bit_in)))
        else $error("carry flag wrong after bit and");

    bit_move_a: assert property (
        ce && alu_valid && alu_op == OP_MOV_C ##1 ce && !alu_valid && !wr_flags
        |=> flags_r[`CARRY_POS] == $past(bit_in, 2))
        else $error("moved bit not held in carry flag");

    half_carry_a: assert property (
        ce && alu_valid && alu_op == OP_ADD |=> flags_r[`HALF_POS] == $past(ref_nib[4]))
        else $error("half carry flag does not match nibble carry");

    user_hold_a: assert property (
        ce && !wr_flags |=> $stable(flags_r[`USER0_POS]) && $stable(flags_r[`USER1_POS]))
        else $error("user flag changed without a write");

    user_write_a: assert property (
        ce && wr_flags
        |=> flags_r[`USER0_POS] == $past(reg_wdata[`USER0_POS])
            && flags_r[`USER1_POS] == $past(reg_wdata[`USER1_POS]))
        else $error("user flag did not take written value");

    signed_range_a: assert property (
        ce && alu_valid && alu_op == OP_ADD |=> flags_r[`SIGNED_POS] == $past(ref_ovf))
        else $error("signed range flag wrong after add");

    parity_track_a: assert property (
        flags_r[`PARITY_POS] == parity_of(work_r))
        else $error("parity bit disagrees with work register");

    bank_map_a: assert property (
        bank_base_r == bank_base_of(flags_r[`BANKH_POS:`BANKL_POS]))
        else $error("bank base does not follow select bits");

    work_access_a: assert property (
        ce && reg_wr && reg_addr == `WORK_REG_ADDR && !alu_valid ##1 ce && reg_rd
        && reg_addr == `WORK_REG_ADDR && !reg_wr |=> reg_rdata == $past(reg_wdata, 2))
        else $error("work register read back wrong");

    flags_read_a: assert property (
        ce && reg_rd && reg_addr == `FLAGS_REG_ADDR |=> reg_rdata == $past(flags_r))
        else $error("flag word read data wrong");

    parity_write_a: assert property (
        ce && wr_flags && !alu_valid
        |=> flags_r[`PARITY_POS] == parity_of($past(work_r)))
        else $error("write to parity bit took effect");

    add_result_a: assert property (
        ce && alu_valid && alu_op == OP_ADD |=> work_r == $past(ref_add[7:0]))
        else $error("work register wrong after add");

    carry_on_addc_a: assert property (
        ce && alu_valid && alu_op == OP_ADDC |=> flags_r[`CARRY_POS] == $past(ref_addc[8]))
        else $error("carry flag does not match add with carry");

    // Carry holds the borrow after a subtract
    borrow_on_subb_a: assert property (
        ce && alu_valid && alu_op == OP_SUBB
        |=> flags_r[`CARRY_POS] == $past(ref_sub[8]) && work_r == $past(ref_sub[7:0]))
        else $error("borrow or difference wrong after subtract");

    bit_complement_a: assert property (
        ce && alu_valid && alu_op == OP_CPL_C |=> flags_r[`CARRY_POS] != $past(flags_r[`CARRY_POS]))
        else $error("carry flag not inverted");

    bit_set_clear_a: assert property (
        ce && alu_valid && (alu_op == OP_SET_C || alu_op == OP_CLR_C)
        |=> flags_r[`CARRY_POS] == ($past(alu_op) == OP_SET_C))
        else $error("carry flag not forced by set or clear");

    bit_or_a: assert property (
        ce && alu_valid && alu_op == OP_OR_C
        |=> flags_r[`CARRY_POS] == ($past(flags_r[`CARRY_POS]) | $past(bit_in)))
        else $error("carry flag wrong after bit or");

    work_keep_a: assert property (
        ce && alu_valid && !is_arith(alu_op) && !reg_wr |=> $stable(work_r))
        else $error("bit operation changed work register");

    half_borrow_a: assert property (
        ce && alu_valid && alu_op == OP_SUBB |=> flags_r[`HALF_POS] == $past(ref_nib_sub[4]))
        else $error("half carry flag does not match nibble borrow");

    arith_flags_keep_a: assert property (
        ce && alu_valid && !is_arith(alu_op) && !wr_flags
        |=> $stable(flags_r[`HALF_POS]) && $stable(flags_r[`SIGNED_POS]))
        else $error("bit operation changed half carry or signed range flag");

    work_write_a: assert property (
        ce && reg_wr && reg_addr == `WORK_REG_ADDR && !alu_valid |=> work_r == $past(reg_wdata))
        else $error("work register did not take written value");

    // Idle read data keep a stale byte from being taken twice
    rdata_idle_a: assert property (
        ce && !reg_rd |=> reg_rdata == `RDATA_IDLE)
        else $error("read data not idle outside answer cycle");

    unmapped_write_a: assert property (
        ce && wr_other && !alu_valid |=> $stable(work_r) && $stable(flags_r))
        else $error("write to unmapped address changed state");

    unmapped_read_a: assert property (
        ce && rd_other |=> reg_rdata == `RDATA_IDLE)
        else $error("read of unmapped address not idle");

    cover_add_carry_c: cover property (ce && alu_valid && alu_op == OP_ADD && ref_add[8]);
    cover_subb_c: cover property (ce && alu_valid && alu_op == OP_SUBB ##1 flags_r[`CARRY_POS]);
    cover_bank3_c: cover property (bank_base_r == bank_base_of(2'b11));
    cover_read_flags_c: cover property (ce && reg_rd && reg_addr == `FLAGS_REG_ADDR);
    cover_back_to_back_c: cover property (ce && reg_wr ##1 ce && reg_rd);

endmodule

// ---- dv/tb_program_status_flags.sv ----
// Directed bench for the work register and status flag word
`timescale 1ns/1ps
`include "flagword_cfg.svh"

module tb_program_status_flags;
    import flagword_pkg::*;

    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        alu_valid = 1'b0;
    alu_op_t     alu_op = OP_NONE;
    logic [7:0]  alu_operand = 8'h00;
    logic        bit_in = 1'b0;
    logic [7:0]  work_value;
    logic [7:0]  flags_value;
    logic [7:0]  bank_base;
    int          err_total = 0;
    int          comparisons = 0;
    logic [15:0] exp_af;
    alu_op_t     aops[6] = '{OP_ADD, OP_ADD, OP_ADDC, OP_SUBB, OP_SUBB, OP_ADD};
    logic [7:0]  av[6] = '{8'hFF, 8'h7F, 8'h80, 8'h00, 8'h80, 8'h08};
    logic [7:0]  bv[6] = '{8'h01, 8'h01, 8'h80, 8'h01, 8'h01, 8'h08};
    logic        cv[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    alu_op_t     bops[9] = '{OP_NONE, OP_CLR_C, OP_SET_C, OP_CPL_C, OP_AND_C, OP_ANDN_C, OP_OR_C, OP_ORN_C, OP_MOV_C};

    always #10 clk_sys = ~clk_sys;

    program_status_flags program_status_flags_inst (.clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alu_valid(alu_valid),
        .alu_op(alu_op), .alu_operand(alu_operand), .bit_in(bit_in), .work_value(work_value),
        .flags_value(flags_value), .bank_base(bank_base));

    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // Checks the answer cycle and the idle cycle after it
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 cmp8("reg_rdata", exp, reg_rdata);
        @(posedge clk_sys);
        #1 cmp8("reg_rdata idle", `RDATA_IDLE, reg_rdata);
    endtask

    // Write then read back with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] addr, input logic [7:0] data, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk_sys);
        reg_rd    <= 1'b0;
        #1 cmp8("reg_rdata back to back", exp, reg_rdata);
        @(posedge clk_sys);
        #1 cmp8("reg_rdata idle", `RDATA_IDLE, reg_rdata);
    endtask

    task automatic alu(input alu_op_t op, input logic [7:0] opnd, input logic b);
        @(posedge clk_sys);
        alu_valid   <= 1'b1;
        alu_op      <= op;
        alu_operand <= opnd;
        bit_in      <= b;
        @(posedge clk_sys);
        alu_valid   <= 1'b0;
        #1;
    endtask

    // Expected work value and flags; user bits 5 and 1 preset to one
    function automatic logic [15:0] arith(input alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                                          input logic c);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] l;
        logic [7:0] bb;
        logic       ci;
        logic       sub;
        sub = (op == OP_SUBB);
        bb  = sub ? ~b : b;
        ci  = (op == OP_ADD) ? 1'b0 : (sub ? ~c : c);
        s   = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
        h   = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        l   = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
        return {s[7:0], s[8] ^ sub, h[4] ^ sub, 3'b100, l[7] ^ s[8], 1'b1, ^s[7:0]};
    endfunction

    function automatic logic bitref(input alu_op_t op, input logic c, input logic b);
        case (op)
            OP_CLR_C:  return 1'b0;
            OP_SET_C:  return 1'b1;
            OP_CPL_C:  return ~c;
            OP_AND_C:  return c & b;
            OP_ANDN_C: return c & ~b;
            OP_OR_C:   return c | b;
            OP_ORN_C:  return c | ~b;
            OP_MOV_C:  return b;
            default:   return c;
        endcase
    endfunction

    task automatic close_out;
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole sequence needs well under 2000 cycles
    initial begin
        #(20 * 5000);
        err_total++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        #1 cmp8("work_value", `WORK_RST, work_value);
        cmp8("flags_value", `FLAGS_RST, flags_value);
        cmp8("bank_base", `BANK_BASE_RST, bank_base);
        $display("test reset done");
        wr(`WORK_REG_ADDR, 8'h55);
        rd(`WORK_REG_ADDR, 8'h55);
        cmp8("parity even", 8'h00, flags_value);
        wr(`FLAGS_REG_ADDR, 8'h23);
        rd(`FLAGS_REG_ADDR, 8'h22);
        wr(`WORK_REG_ADDR, 8'h07);
        #1 cmp8("parity odd", 8'h23, flags_value);
        wr(8'hD8, 8'hFF);
        rd(8'hD8, 8'h00);
        rd(`FLAGS_REG_ADDR, 8'h23);
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(`WORK_REG_ADDR, 8'hAA);
        ce <= 1'b1;
        rd(`WORK_REG_ADDR, 8'h07);
        wr_rd(`WORK_REG_ADDR, 8'hC3, 8'hC3);
        $display("test register access done");
        wr(`WORK_REG_ADDR, 8'h55);
        for (int k = 0; k < 4; k++) begin
            wr(`FLAGS_REG_ADDR, {3'b000, k[1:0], 3'b000});
            #1 cmp8("bank_base", {3'b000, k[1:0], 3'b000}, bank_base);
        end
        $display("test bank select done");
        for (int i = 0; i < 6; i++) begin
            wr(`WORK_REG_ADDR, av[i]);
            wr(`FLAGS_REG_ADDR, {cv[i], 7'h22});
            exp_af = arith(aops[i], av[i], bv[i], cv[i]);
            alu(aops[i], bv[i], 1'b0);
            cmp8("work_value", exp_af[15:8], work_value);
            cmp8("flags_value", exp_af[7:0], flags_value);
        end
        $display("test arithmetic done");
        wr(`WORK_REG_ADDR, 8'h00);
        foreach (bops[j]) begin
            for (int m = 0; m < 4; m++) begin
                wr(`FLAGS_REG_ADDR, {m[1], 7'h00});
                alu(bops[j], 8'h00, m[0]);
                cmp8("carry bit op", {bitref(bops[j], m[1], m[0]), 7'h00}, flags_value);
            end
        end
        $display("test bit operations done");
        close_out();
    end
endmodule
